//--- hdl/mie_pkg.sv
/*
  Constants for the metering interrupt enable logic: SFR addresses,
  bit positions, write masks and reset values.
  Assumes the 8-bit SFR space of the on-chip core.
*/
`default_nettype none
package mie_pkg;
  // SFR addresses
  localparam logic [7:0] MIE_ADDR_EN_LOW   = 8'hd9;
  localparam logic [7:0] MIE_ADDR_EN_MID   = 8'hda;
  localparam logic [7:0] MIE_ADDR_EN_HIGH  = 8'hdb;
  localparam logic [7:0] MIE_ADDR_ST_LOW   = 8'hdc;
  localparam logic [7:0] MIE_ADDR_ST_MID   = 8'hdd;
  localparam logic [7:0] MIE_ADDR_ST_HIGH  = 8'hde;
  // Mid register bit positions
  localparam int MIE_BIT_FREQ_TWO   = 7;
  localparam int MIE_BIT_FREQ_ONE   = 6;
  localparam int MIE_BIT_APP_OVF    = 5;
  localparam int MIE_BIT_REA_OVF    = 4;
  localparam int MIE_BIT_ACT_OVF    = 3;
  localparam int MIE_BIT_APP_HALF   = 2;
  localparam int MIE_BIT_REA_HALF   = 1;
  localparam int MIE_BIT_ACT_HALF   = 0;
  // High register bit positions
  localparam int MIE_BIT_WAVE_RDY   = 5;
  localparam int MIE_BIT_CUR_PEAK   = 4;
  localparam int MIE_BIT_VOLT_PEAK  = 3;
  localparam int MIE_BIT_CYCLE_DONE = 2;
  localparam int MIE_BIT_ZX_TIMEOUT = 1;
  localparam int MIE_BIT_ZX         = 0;
  // Low status summary position
  localparam int MIE_BIT_SUMMARY    = 7;
  // Writable masks and reset values
  localparam logic [7:0] MIE_MASK_MID      = 8'hff;
  localparam logic [7:0] MIE_MASK_HIGH     = 8'h3f;
  localparam logic [7:0] MIE_MASK_LOW      = 8'h3f;
  localparam logic [7:0] MIE_MASK_REACTIVE = 8'h12;
  localparam logic [7:0] MIE_RESET_VAL     = 8'h00;
endpackage
`default_nettype wire

//--- hdl/mie_wr_if.sv
/*
  Write strobe and data from the SFR decoder to the register slices.
  Assumes one clock domain and a single decoder driving it.
*/
`timescale 1ns/1ns
`default_nettype none
interface mie_wr_if;
  logic [7:0] wdata;
  logic       wr;
  // Decoder side drives, register side listens
  modport ctl (output wdata, output wr);
  modport slv (input wdata, input wr);
endinterface
`default_nettype wire

//--- hdl/mie_sfr_reg.sv
/*
  One 8-bit SFR slice: a plain enable register or a sticky status
  register whose flags hardware sets and software clears by writing 0.
  Assumes set pulses from logic on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
module mie_sfr_reg
  import mie_pkg::*;
#(
  parameter logic [7:0] WMASK  = 8'hff,
  parameter bit         STICKY = 1'b0
) (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // Write port
  mie_wr_if.slv           wr_bus,
  input  wire logic       i_sel,
  // Hardware set pulses
  input  wire logic [7:0] i_set,
  // Register value
  output logic      [7:0] o_q
);
  logic [7:0] q_reg;
  logic [7:0] q_next;
  wire        wr_hit = wr_bus.wr & i_sel;
  wire  [7:0] plain_next  = wr_hit ? (wr_bus.wdata & WMASK) : q_reg;
  // Clearing write keeps ones, set wins over a clear in the same cycle
  wire  [7:0] sticky_hold = wr_hit ? (q_reg & wr_bus.wdata) : q_reg;
  wire  [7:0] sticky_next = (sticky_hold | i_set) & WMASK;

  assign q_next = STICKY ? sticky_next : plain_next;
  assign o_q    = q_reg;

  // Register update, zero at reset
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q_reg <= MIE_RESET_VAL;
    end else begin
      q_reg <= q_next;
    end
  end
endmodule
`default_nettype wire

//--- hdl/mie_irq_enable.sv
/*
  Metering interrupt enable logic: mid and high enable SFRs, mid and
  high status flags, summary flag and the shared interrupt request.
  Assumes the core's SFR strobes on i_clk; the low status flags and
  low enable register live in a neighbouring block and arrive as
  levels; event pulses come from metering logic on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
module mie_irq_enable
  import mie_pkg::*;
#(
  parameter bit P_HAS_REACTIVE = 1'b1
) (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // SFR access from the core
  input  wire logic [7:0] i_sfr_addr,
  input  wire logic [7:0] i_sfr_wdata,
  input  wire logic       i_sfr_wr,
  input  wire logic       i_sfr_rd,
  output logic      [7:0] o_sfr_rdata,
  output logic            o_sfr_hit,
  // Mid-group events, one-cycle pulses
  input  wire logic       i_freq_out_two_pulse,
  input  wire logic       i_freq_out_one_pulse,
  input  wire logic       i_apparent_energy_overflow,
  input  wire logic       i_reactive_energy_overflow,
  input  wire logic       i_active_energy_overflow,
  input  wire logic       i_apparent_energy_half_full,
  input  wire logic       i_reactive_energy_half_full,
  input  wire logic       i_active_energy_half_full,
  // High-group events, one-cycle pulses
  input  wire logic       i_waveform_sample_ready,
  input  wire logic       i_current_peak,
  input  wire logic       i_voltage_peak,
  input  wire logic       i_line_cycle_accum_done,
  input  wire logic       i_zero_cross_timeout,
  input  wire logic       i_zero_cross,
  // Low pair from the neighbouring block, levels
  input  wire logic [7:0] i_status_low,
  input  wire logic [7:0] i_enable_low,
  // Interrupt to the core
  output logic            o_metering_irq,
  output logic            o_metering_irq_summary
);
  mie_wr_if wr_bus ();

  // Address decode
  wire sel_en_mid  = (i_sfr_addr == MIE_ADDR_EN_MID);
  wire sel_en_high = (i_sfr_addr == MIE_ADDR_EN_HIGH);
  wire sel_st_low  = (i_sfr_addr == MIE_ADDR_ST_LOW);
  wire sel_st_mid  = (i_sfr_addr == MIE_ADDR_ST_MID);
  wire sel_st_high = (i_sfr_addr == MIE_ADDR_ST_HIGH);
  wire sel_any     = sel_en_mid | sel_en_high | sel_st_low |
                     sel_st_mid | sel_st_high;

  assign wr_bus.wdata = i_sfr_wdata;
  assign wr_bus.wr    = i_sfr_wr;

  // Mid event vector; pulses are taken before any pin gating
  logic [7:0] set_mid;
  assign set_mid[MIE_BIT_FREQ_TWO] = i_freq_out_two_pulse;
  assign set_mid[MIE_BIT_FREQ_ONE] = i_freq_out_one_pulse;
  assign set_mid[MIE_BIT_APP_OVF]  = i_apparent_energy_overflow;
  assign set_mid[MIE_BIT_REA_OVF]  = i_reactive_energy_overflow;
  assign set_mid[MIE_BIT_ACT_OVF]  = i_active_energy_overflow;
  assign set_mid[MIE_BIT_APP_HALF] = i_apparent_energy_half_full;
  assign set_mid[MIE_BIT_REA_HALF] = i_reactive_energy_half_full;
  assign set_mid[MIE_BIT_ACT_HALF] = i_active_energy_half_full;

  // High event vector, bits 7:6 unused
  logic [7:0] set_high;
  assign set_high[7:6]                = 2'h0;
  assign set_high[MIE_BIT_WAVE_RDY]   = i_waveform_sample_ready;
  assign set_high[MIE_BIT_CUR_PEAK]   = i_current_peak;
  assign set_high[MIE_BIT_VOLT_PEAK]  = i_voltage_peak;
  assign set_high[MIE_BIT_CYCLE_DONE] = i_line_cycle_accum_done;
  assign set_high[MIE_BIT_ZX_TIMEOUT] = i_zero_cross_timeout;
  assign set_high[MIE_BIT_ZX]         = i_zero_cross;

  logic [7:0] en_mid;
  logic [7:0] en_high;
  logic [7:0] st_mid;
  logic [7:0] st_high;

  // Enable registers
  mie_sfr_reg #(.WMASK(MIE_MASK_MID), .STICKY(1'b0)) u_en_mid (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .wr_bus  (wr_bus),
    .i_sel   (sel_en_mid),
    .i_set   (8'h00),
    .o_q     (en_mid)
  );
  mie_sfr_reg #(.WMASK(MIE_MASK_HIGH), .STICKY(1'b0)) u_en_high (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .wr_bus  (wr_bus),
    .i_sel   (sel_en_high),
    .i_set   (8'h00),
    .o_q     (en_high)
  );

  // Status registers, software writes 0 to clear
  mie_sfr_reg #(.WMASK(MIE_MASK_MID), .STICKY(1'b1)) u_st_mid (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .wr_bus  (wr_bus),
    .i_sel   (sel_st_mid),
    .i_set   (set_mid),
    .o_q     (st_mid)
  );
  mie_sfr_reg #(.WMASK(MIE_MASK_HIGH), .STICKY(1'b1)) u_st_high (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .wr_bus  (wr_bus),
    .i_sel   (sel_st_high),
    .i_set   (set_high),
    .o_q     (st_high)
  );

  // Reactive enables lose their function on variants without it
  wire [7:0] rea_gate = P_HAS_REACTIVE ? 8'hff : ~MIE_MASK_REACTIVE;

  // Mid pair: each flag gated by its own enable bit
  wire [7:0] pend_mid;
  assign pend_mid[MIE_BIT_FREQ_TWO] = st_mid[MIE_BIT_FREQ_TWO] &
                                      en_mid[MIE_BIT_FREQ_TWO];
  assign pend_mid[MIE_BIT_FREQ_ONE] = st_mid[MIE_BIT_FREQ_ONE] &
                                      en_mid[MIE_BIT_FREQ_ONE];
  assign pend_mid[MIE_BIT_APP_OVF]  = st_mid[MIE_BIT_APP_OVF] &
                                      en_mid[MIE_BIT_APP_OVF];
  assign pend_mid[MIE_BIT_REA_OVF]  = st_mid[MIE_BIT_REA_OVF] &
                                      en_mid[MIE_BIT_REA_OVF] &
                                      rea_gate[MIE_BIT_REA_OVF];
  assign pend_mid[MIE_BIT_ACT_OVF]  = st_mid[MIE_BIT_ACT_OVF] &
                                      en_mid[MIE_BIT_ACT_OVF];
  assign pend_mid[MIE_BIT_APP_HALF] = st_mid[MIE_BIT_APP_HALF] &
                                      en_mid[MIE_BIT_APP_HALF];
  assign pend_mid[MIE_BIT_REA_HALF] = st_mid[MIE_BIT_REA_HALF] &
                                      en_mid[MIE_BIT_REA_HALF] &
                                      rea_gate[MIE_BIT_REA_HALF];
  assign pend_mid[MIE_BIT_ACT_HALF] = st_mid[MIE_BIT_ACT_HALF] &
                                      en_mid[MIE_BIT_ACT_HALF];

  // High pair
  wire [7:0] pend_high;
  assign pend_high[7:6]                = 2'h0;
  assign pend_high[MIE_BIT_WAVE_RDY]   = st_high[MIE_BIT_WAVE_RDY] &
                                         en_high[MIE_BIT_WAVE_RDY];
  assign pend_high[MIE_BIT_CUR_PEAK]   = st_high[MIE_BIT_CUR_PEAK] &
                                         en_high[MIE_BIT_CUR_PEAK];
  assign pend_high[MIE_BIT_VOLT_PEAK]  = st_high[MIE_BIT_VOLT_PEAK] &
                                         en_high[MIE_BIT_VOLT_PEAK];
  assign pend_high[MIE_BIT_CYCLE_DONE] = st_high[MIE_BIT_CYCLE_DONE] &
                                         en_high[MIE_BIT_CYCLE_DONE];
  assign pend_high[MIE_BIT_ZX_TIMEOUT] = st_high[MIE_BIT_ZX_TIMEOUT] &
                                         en_high[MIE_BIT_ZX_TIMEOUT];
  assign pend_high[MIE_BIT_ZX]         = st_high[MIE_BIT_ZX] &
                                         en_high[MIE_BIT_ZX];

  // Low pair, positions 5:0 only
  wire [7:0] pend_low = i_status_low & i_enable_low & MIE_MASK_LOW;

  // Any enabled flag raises the request; it drops when the flag or its enable bit is cleared
  wire any_pend = (|pend_low) | (|pend_mid) | (|pend_high);

  // Request and summary, registered
  logic irq_reg;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= any_pend;
    end
  end
  assign o_metering_irq         = irq_reg;
  assign o_metering_irq_summary = irq_reg;

  // Read data selection; low status carries summary in bit 7
  wire [7:0] st_low_view = {irq_reg, 1'b0, i_status_low[5:0]};
  wire [7:0] rd_sel =
      sel_en_mid  ? en_mid :
      sel_en_high ? (en_high & MIE_MASK_HIGH) :
      sel_st_low  ? st_low_view :
      sel_st_mid  ? st_mid :
      sel_st_high ? st_high : 8'h00;

  // Read data and hit flag, one cycle after the read strobe
  logic [7:0] rdata_reg;
  logic       hit_reg;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_reg <= 8'h00;
      hit_reg   <= 1'b0;
    end else begin
      rdata_reg <= i_sfr_rd ? rd_sel : rdata_reg;
      hit_reg   <= i_sfr_rd & sel_any;
    end
  end
  assign o_sfr_rdata = rdata_reg;
  assign o_sfr_hit   = hit_reg;
endmodule
`default_nettype wire

//--- verification/mie_core_model.sv
/* Model of the core's interrupt input: counts handler entries.
   Assumes the request is a level on the block clock. */
`timescale 1ns/1ns
`default_nettype none
module mie_core_model (
  // Clock, reset and request
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_irq,
  // Number of handler entries seen
  output logic      [7:0] o_entries
);
  logic irq_reg;
  // A new entry on each rising request, as an edge-sensing core sees it
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_reg   <= 1'b0;
      o_entries <= 8'h00;
    end else begin
      irq_reg <= i_irq;
      if (i_irq && !irq_reg) o_entries <= o_entries + 8'h01;
    end
  end
endmodule
`default_nettype wire

//--- verification/mie_irq_monitor.sv
/* Port checker for the metering interrupt enable logic.
   Assumes one clock domain; attached by the bind at the foot. */
`timescale 1ns/1ns
`default_nettype none
module mie_irq_monitor
  import mie_pkg::*;
(
  input wire logic       i_clk,
  input wire logic       i_rst_n,
  input wire logic [7:0] i_sfr_addr,
  input wire logic       i_sfr_wr,
  input wire logic       i_sfr_rd,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic       o_sfr_hit,
  input wire logic [7:0] i_status_low,
  input wire logic [7:0] i_enable_low,
  input wire logic       o_metering_irq,
  input wire logic       o_metering_irq_summary
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // Decode and low-pair request as seen from the pins
  wire mapped = i_sfr_addr >= MIE_ADDR_EN_MID &&
                i_sfr_addr <= MIE_ADDR_ST_HIGH;
  wire low_nz = |(i_status_low & i_enable_low & MIE_MASK_LOW);
  a_low_pair_irq: assert property (low_nz |=> o_metering_irq)
    else $error("low pair raised no request");
  a_summary_same: assert property (
    o_metering_irq_summary == o_metering_irq)
    else $error("summary differs from request");
  a_hit_mapped: assert property (i_sfr_rd && mapped |=> o_sfr_hit)
    else $error("mapped read gave no hit");
  a_unmapped_zero: assert property (i_sfr_rd && !mapped
    |=> !o_sfr_hit && o_sfr_rdata == 8'h00) else $error("unmapped read");
  a_high_reserved: assert property (
    i_sfr_rd && i_sfr_addr == MIE_ADDR_EN_HIGH
    |=> o_sfr_rdata[7:6] == 2'b00) else $error("reserved bits set");
  a_low_status_read: assert property (
    i_sfr_rd && i_sfr_addr == MIE_ADDR_ST_LOW
    |=> o_sfr_rdata == {$past(o_metering_irq_summary), 1'b0,
    $past(i_status_low[5:0])}) else $error("low status read wrong");
  a_rdata_hold: assert property (!i_sfr_rd |=> $stable(o_sfr_rdata))
    else $error("read data moved without a read");
  a_irq_fall_cause: assert property ($fell(o_metering_irq)
    |-> $past(i_sfr_wr, 2) || !$past(low_nz)) else $error("request dropped");
endmodule
bind mie_irq_enable mie_irq_monitor u_mon (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd),
  .o_sfr_rdata(o_sfr_rdata), .o_sfr_hit(o_sfr_hit),
  .i_status_low(i_status_low), .i_enable_low(i_enable_low),
  .o_metering_irq(o_metering_irq),
  .o_metering_irq_summary(o_metering_irq_summary));
`default_nettype wire

//--- verification/metering_irq_enable_logic_test.sv
/* Self-checking bench for the metering interrupt enable logic.
   Assumes the core model and the bound port checker. */
`timescale 1ns/1ns
`default_nettype none
module metering_irq_enable_logic_test
  import mie_pkg::*;
;
  logic       i_clk, i_rst_n, wr, rd, hi;
  logic [7:0] addr, wdata, s_low, e_low, ev_mid, m, rdata, entries;
  logic [5:0] ev_high;
  logic       irq, summ, hit, irq_nr;
  logic [31:0] seed;
  logic [7:0] exp_q[$];
  int         n_mismatch, total_checks, b;
  mie_irq_enable DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_sfr_addr(addr),
    .i_sfr_wdata(wdata), .i_sfr_wr(wr), .i_sfr_rd(rd), .o_sfr_rdata(rdata),
    .o_sfr_hit(hit), .i_freq_out_two_pulse(ev_mid[7]),
    .i_freq_out_one_pulse(ev_mid[6]),
    .i_apparent_energy_overflow(ev_mid[5]),
    .i_reactive_energy_overflow(ev_mid[4]),
    .i_active_energy_overflow(ev_mid[3]),
    .i_apparent_energy_half_full(ev_mid[2]),
    .i_reactive_energy_half_full(ev_mid[1]),
    .i_active_energy_half_full(ev_mid[0]),
    .i_waveform_sample_ready(ev_high[5]), .i_current_peak(ev_high[4]),
    .i_voltage_peak(ev_high[3]), .i_line_cycle_accum_done(ev_high[2]),
    .i_zero_cross_timeout(ev_high[1]), .i_zero_cross(ev_high[0]),
    .i_status_low(s_low), .i_enable_low(e_low), .o_metering_irq(irq),
    .o_metering_irq_summary(summ));
  mie_core_model u_core (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_irq(irq),
    .o_entries(entries));
  // Variant without reactive measurement, fed the same stimulus
  mie_irq_enable #(.P_HAS_REACTIVE(1'b0)) u_no_rea (.i_clk(i_clk),
    .i_rst_n(i_rst_n), .i_sfr_addr(addr), .i_sfr_wdata(wdata),
    .i_sfr_wr(wr), .i_sfr_rd(rd), .o_sfr_rdata(), .o_sfr_hit(),
    .i_freq_out_two_pulse(ev_mid[7]), .i_freq_out_one_pulse(ev_mid[6]),
    .i_apparent_energy_overflow(ev_mid[5]),
    .i_reactive_energy_overflow(ev_mid[4]),
    .i_active_energy_overflow(ev_mid[3]),
    .i_apparent_energy_half_full(ev_mid[2]),
    .i_reactive_energy_half_full(ev_mid[1]),
    .i_active_energy_half_full(ev_mid[0]),
    .i_waveform_sample_ready(ev_high[5]), .i_current_peak(ev_high[4]),
    .i_voltage_peak(ev_high[3]), .i_line_cycle_accum_done(ev_high[2]),
    .i_zero_cross_timeout(ev_high[1]), .i_zero_cross(ev_high[0]),
    .i_status_low(s_low), .i_enable_low(e_low), .o_metering_irq(irq_nr),
    .o_metering_irq_summary());
  // Clock, 10 ns period
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input string nm, input logic [7:0] seen,
                       input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick();
    @(posedge i_clk);
    #1;
  endtask
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    tick();
    wr = 1'b0;
    tick();
  endtask
  // Expected read data is noted before the strobe goes out
  task automatic sfr_rd(input logic [7:0] a, input logic [7:0] e,
                        input bit mapped);
    addr = a;
    rd = 1'b1;
    if (mapped) exp_q.push_back(e);
    tick();
    rd = 1'b0;
    tick();
  endtask
  task automatic pulse(input int i);
    if (i < 8) ev_mid[i] = 1'b1;
    else ev_high[i-8] = 1'b1;
    tick();
    ev_mid = 8'h00;
    ev_high = 6'h00;
    tick();
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Read results are matched against the oldest note
  always @(negedge i_clk) begin
    if (hit === 1'b1) begin
      if (exp_q.size() == 0) check("hit", 8'h01, 8'h00);
      else check("rdata", rdata, exp_q.pop_front());
    end
  end
  // Watchdog
  initial begin
    #100000;
    n_mismatch++;
    end_of_test();
  end
  initial begin
    {wr, rd, addr, wdata, s_low, e_low, ev_mid, ev_high} = '0;
    i_rst_n = 1'b0;
    seed = 32'h8831ad38;
    repeat (8) @(posedge i_clk);
    #1 i_rst_n = 1'b1;
    check("irq", irq, 8'h00);
    sfr_rd(MIE_ADDR_EN_MID, 8'h00, 1);
    sfr_rd(MIE_ADDR_EN_HIGH, 8'h00, 1);
    seed = lfsr_next(seed);
    sfr_wr(MIE_ADDR_EN_MID, seed[7:0]);
    sfr_rd(MIE_ADDR_EN_MID, seed[7:0], 1);
    sfr_wr(MIE_ADDR_EN_HIGH, 8'hff);
    sfr_rd(MIE_ADDR_EN_HIGH, MIE_MASK_HIGH, 1);
    // Each source: disabled, then enabled, held, then cleared
    for (int i = 0; i < 14; i++) begin
      hi = (i >= 8);
      b = hi ? i - 8 : i;
      m = 8'h01 << b;
      sfr_wr(MIE_ADDR_EN_MID, 8'h00);
      sfr_wr(MIE_ADDR_EN_HIGH, 8'h00);
      sfr_wr(MIE_ADDR_ST_MID, 8'h00);
      sfr_wr(MIE_ADDR_ST_HIGH, 8'h00);
      pulse(i);
      check("irq masked", irq, 8'h00);
      sfr_rd(hi ? MIE_ADDR_ST_HIGH : MIE_ADDR_ST_MID, m, 1);
      sfr_wr(hi ? MIE_ADDR_EN_HIGH : MIE_ADDR_EN_MID, m);
      if (!hi) check("irq mid", irq, 8'h01);
      else check("irq high", irq, 8'h01);
      check("irq no rea", irq_nr, {7'h00, hi ||
            (b != MIE_BIT_REA_OVF && b != MIE_BIT_REA_HALF)});
      repeat (3) tick();
      check("irq held", irq, 8'h01);
      sfr_wr(hi ? MIE_ADDR_ST_HIGH : MIE_ADDR_ST_MID, ~m);
      check("irq cleared", irq, 8'h00);
    end
    check("entries", entries, 8'd14);
    // Random low pair
    repeat (4) begin
      seed = lfsr_next(seed);
      s_low = seed[7:0];
      e_low = seed[15:8];
      m = {7'h00, |(s_low & e_low & MIE_MASK_LOW)};
      tick();
      check("irq low", irq, m);
      check("summary", summ, m);
      sfr_rd(MIE_ADDR_ST_LOW, {m[0], 1'b0, s_low[5:0]}, 1);
    end
    sfr_rd(MIE_ADDR_EN_LOW, 8'h00, 0);
    check("unmapped", rdata, 8'h00);
    // Mid-run reset: enables and request return to zero
    i_rst_n = 1'b0;
    tick();
    i_rst_n = 1'b1;
    check("irq reset", irq, 8'h00);
    sfr_rd(MIE_ADDR_EN_HIGH, 8'h00, 1);
    tick();
    check("queue", 8'(exp_q.size()), 8'h00);
    end_of_test();
  end
endmodule
`default_nettype wire
